// ---- logic/infrared_frame_control.sv ----
// Purpose: control register and frame control for medium/fast infrared codecs
// Assumes: one clock; codec datapaths, FIFOs and select register sit outside
// Notes:   drops and flushes are signalled as one-cycle or level controls
`include "ir_ctrl_map.svh"
module infrared_frame_control (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    // Control register port
    input  wire logic        ctl_wr_i,
    input  wire logic [7:0]  ctl_wdata_i,
    output logic      [7:0]  ctl_rdata_o,
    // Codec selection and match value
    input  wire logic [1:0]  codec_sel_i,
    input  wire logic [7:0]  addr_filter_value_i,
    input  wire logic        src_tick_i,
    // Receive side events
    input  wire logic        rx_line_i,
    input  wire logic        rx_flag_i,
    input  wire logic        rx_byte_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_stop_i,
    // Buffer status
    input  wire logic        transmit_underrun_flag_i,
    input  wire logic        tx_data_avail_i,
    input  wire logic        transmit_service_flag_i,
    input  wire logic        receive_service_flag_i,
    input  wire logic        end_error_in_fifo_flag_i,
    input  wire logic        tx_close_done_i,
    // Outputs to codecs
    output logic             bit_tick_o,
    output logic             rx_clk_en_o,
    output logic             tx_clk_en_o,
    output logic             slow_en_o,
    output logic             tx_flush_o,
    output logic             rx_flush_o,
    output logic             tx_send_close_o,
    output logic             tx_send_abort_o,
    output logic             rx_store_o,
    // Requests
    output logic             tx_irq_o,
    output logic             rx_irq_o,
    output logic             underrun_irq_o,
    output logic             tx_dma_o,
    output logic             rx_dma_o
);
    ir_ctrl_pkg::infrared_control_s ctl_r;
    ir_ctrl_pkg::rx_state_e         rx_st_r, rx_st_nxt;
    ir_ctrl_pkg::tx_state_e         tx_st_r, tx_st_nxt;
    logic                           rx_line_r;
    logic                           bit_tick;

    // Codec decode
    wire sel_med   = (codec_sel_i == `SEL_MED);
    wire sel_fast  = (codec_sel_i == `SEL_FAST);
    wire sel_slow  = (codec_sel_i == `SEL_SLOW);
    wire frame_sel = sel_med || sel_fast;
    wire tx_on     = frame_sel && ctl_r.transmit_enable_bit;
    wire rx_on     = frame_sel && ctl_r.receive_enable_bit;
    wire rx_rise   = rx_on && rx_line_i && !rx_line_r;
    wire rate_hi   = sel_med && ctl_r.medium_rate_select;
    wire [7:0] wr_val = ctl_wdata_i & `CTL_WMASK;
    wire tx_off_wr = ctl_wr_i && ctl_r.transmit_enable_bit && !wr_val[`CTL_TXEN_BIT];
    wire rx_off_wr = ctl_wr_i && ctl_r.receive_enable_bit && !wr_val[`CTL_RXEN_BIT];
    wire addr_hit  = (rx_data_i == addr_filter_value_i) || (rx_data_i == `BCAST_ADDR);
    wire uflow     = tx_on && transmit_underrun_flag_i;

    bit_clock_gen u_bitclk (
        .clk_sys_i  (clk_sys_i),
        .resetn_i   (resetn_i),
        .run_i      (sel_med && (tx_on || rx_on)),
        .fast_i     (rate_hi),
        .restart_i  (rx_rise),
        .src_tick_i (src_tick_i),
        .bit_tick_o (bit_tick)
    );

    // Control register; bits 7 to 1 writable while live, bit 0 held at zero
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i)
            ctl_r <= `CTL_RESET;
        else if (ctl_wr_i)
            ctl_r <= wr_val;
    end

    // Receive frame address filter
    always_comb begin
        rx_st_nxt = rx_st_r;
        case (rx_st_r)
            ir_ctrl_pkg::RX_HUNT: if (rx_flag_i) rx_st_nxt = ir_ctrl_pkg::RX_ADDR;
            ir_ctrl_pkg::RX_ADDR: if (rx_byte_i) begin
                if (!ctl_r.addr_filter_enable || addr_hit)
                    rx_st_nxt = ir_ctrl_pkg::RX_KEEP;
                else
                    rx_st_nxt = ir_ctrl_pkg::RX_DROP;
            end
            ir_ctrl_pkg::RX_KEEP: if (rx_stop_i) rx_st_nxt = ir_ctrl_pkg::RX_HUNT;
            ir_ctrl_pkg::RX_DROP: if (rx_stop_i) rx_st_nxt = ir_ctrl_pkg::RX_HUNT;
            default:              rx_st_nxt = ir_ctrl_pkg::RX_HUNT;
        endcase
        if (!rx_on)
            rx_st_nxt = ir_ctrl_pkg::RX_HUNT;
    end

    // Underrun handling
    always_comb begin
        tx_st_nxt = tx_st_r;
        case (tx_st_r)
            ir_ctrl_pkg::TX_DATA:
                if (uflow)
                    tx_st_nxt = ctl_r.underrun_action_select ? ir_ctrl_pkg::TX_ABORT
                                                              : ir_ctrl_pkg::TX_CLOSE;
            ir_ctrl_pkg::TX_CLOSE: if (tx_close_done_i) tx_st_nxt = ir_ctrl_pkg::TX_DATA;
            ir_ctrl_pkg::TX_ABORT: if (tx_data_avail_i) tx_st_nxt = ir_ctrl_pkg::TX_DATA;
            default:               tx_st_nxt = ir_ctrl_pkg::TX_DATA;
        endcase
        if (!tx_on)
            tx_st_nxt = ir_ctrl_pkg::TX_DATA;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_st_r   <= ir_ctrl_pkg::RX_HUNT;
            tx_st_r   <= ir_ctrl_pkg::TX_DATA;
            rx_line_r <= 1'b0;
        end else begin
            rx_st_r   <= rx_st_nxt;
            tx_st_r   <= tx_st_nxt;
            rx_line_r <= rx_line_i;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_rdata_o     <= 8'h00;
            bit_tick_o      <= 1'b0;
            rx_clk_en_o     <= 1'b0;
            tx_clk_en_o     <= 1'b0;
            slow_en_o       <= 1'b0;
            tx_flush_o      <= 1'b0;
            rx_flush_o      <= 1'b0;
            tx_send_close_o <= 1'b0;
            tx_send_abort_o <= 1'b0;
            rx_store_o      <= 1'b0;
            tx_irq_o        <= 1'b0;
            rx_irq_o        <= 1'b0;
            underrun_irq_o  <= 1'b0;
            tx_dma_o        <= 1'b0;
            rx_dma_o        <= 1'b0;
        end else begin
            ctl_rdata_o     <= ctl_r & `CTL_WMASK;
            bit_tick_o      <= bit_tick;
            tx_clk_en_o     <= tx_on;
            rx_clk_en_o     <= rx_on;
            slow_en_o       <= sel_slow;
            tx_flush_o      <= tx_off_wr;
            rx_flush_o      <= rx_off_wr;
            tx_send_close_o <= (tx_st_nxt == ir_ctrl_pkg::TX_CLOSE);
            tx_send_abort_o <= (tx_st_nxt == ir_ctrl_pkg::TX_ABORT);
            rx_store_o      <= (rx_st_nxt == ir_ctrl_pkg::RX_KEEP);
            tx_irq_o        <= ctl_r.transmit_irq_mask && transmit_service_flag_i;
            rx_irq_o        <= ctl_r.receive_irq_mask && receive_service_flag_i;
            underrun_irq_o  <= ctl_r.underrun_action_select
                               && transmit_underrun_flag_i;
            tx_dma_o        <= transmit_service_flag_i;
            rx_dma_o        <= receive_service_flag_i
                               && !end_error_in_fifo_flag_i;
        end
    end

    // Request paths
    a_dma_rx_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rx_dma_o == $past(receive_service_flag_i && !end_error_in_fifo_flag_i))
        else $error("rx dma wrong");
    a_dma_tx_follow: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        tx_dma_o == $past(transmit_service_flag_i))
        else $error("tx dma wrong");
    a_rx_irq_mask: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rx_irq_o == $past(ctl_r.receive_irq_mask && receive_service_flag_i))
        else $error("rx irq wrong");
    a_tx_irq_mask: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        tx_irq_o == $past(ctl_r.transmit_irq_mask && transmit_service_flag_i))
        else $error("tx irq wrong");
    a_underrun_irq_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !ctl_r.underrun_action_select ##1 !ctl_r.underrun_action_select |-> !underrun_irq_o)
        else $error("underrun irq leaked");
    a_underrun_irq_on: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        ctl_r.underrun_action_select && transmit_underrun_flag_i |=> underrun_irq_o)
        else $error("underrun irq missing");

    // Enables fall one cycle after the flush pulse, so the shifters clear first
    a_tx_flush_pulse: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        tx_off_wr |=> tx_flush_o && !ctl_r.transmit_enable_bit)
        else $error("tx flush missing");
    a_rx_flush_pulse: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rx_off_wr |=> rx_flush_o ##1 !rx_flush_o && !rx_clk_en_o
        && rx_st_r == ir_ctrl_pkg::RX_HUNT)
        else $error("rx flush missing");
    a_tx_flush_once: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        tx_flush_o |=> !tx_flush_o)
        else $error("tx flush too long");
    a_rx_flush_once: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rx_flush_o |=> !rx_flush_o)
        else $error("rx flush too long");
    a_tx_clk_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !ctl_r.transmit_enable_bit |=> !tx_clk_en_o)
        else $error("tx clock not gated");
    a_rx_clk_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !ctl_r.receive_enable_bit |=> !rx_clk_en_o)
        else $error("rx clock not gated");
    a_tx_idle_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !tx_on |=> tx_st_r == ir_ctrl_pkg::TX_DATA && !tx_send_close_o && !tx_send_abort_o)
        else $error("tx not stopped");
    a_rx_idle_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !rx_on |=> rx_st_r == ir_ctrl_pkg::RX_HUNT && !rx_store_o)
        else $error("rx not stopped");
    a_slow_enable: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        sel_slow |=> slow_en_o && !tx_clk_en_o && !rx_clk_en_o)
        else $error("slow enable wrong");
    a_rate_fast_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        sel_fast |-> ##2 !bit_tick_o)
        else $error("medium tick with fast codec");

    // Control register
    a_bit0_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !ctl_rdata_o[0] && !ctl_r.unused0)
        else $error("bit0 not zero");
    a_ctl_write_lands: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        ctl_wr_i |=> ctl_r == ($past(ctl_wdata_i) & `CTL_WMASK))
        else $error("control write lost");

    // Transmit underrun
    a_abort_until: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        tx_on && tx_st_r == ir_ctrl_pkg::TX_DATA && uflow && ctl_r.underrun_action_select
        |=> tx_send_abort_o)
        else $error("abort missing");
    a_abort_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        tx_send_abort_o && tx_on && !tx_data_avail_i |=> tx_send_abort_o)
        else $error("abort ended early");
    a_close_on: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        tx_st_r == ir_ctrl_pkg::TX_DATA && uflow && !ctl_r.underrun_action_select
        |=> tx_send_close_o)
        else $error("close missing");
    a_close_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        tx_send_close_o && tx_on && !tx_close_done_i |=> tx_send_close_o)
        else $error("close ended early");

    // Receive filter; the address byte decides the whole frame
    a_filter_drop: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rx_on && rx_st_r == ir_ctrl_pkg::RX_ADDR && rx_byte_i && ctl_r.addr_filter_enable
        && !addr_hit |=> !rx_store_o)
        else $error("filter failed");
    a_addr_keep: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rx_on && rx_st_r == ir_ctrl_pkg::RX_ADDR && rx_byte_i && ctl_r.addr_filter_enable
        && rx_data_i == addr_filter_value_i |=> rx_store_o)
        else $error("matching frame lost");
    a_bcast_keep: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rx_on && rx_st_r == ir_ctrl_pkg::RX_ADDR && rx_byte_i && ctl_r.addr_filter_enable
        && rx_data_i == `BCAST_ADDR |=> rx_store_o)
        else $error("broadcast frame lost");
    a_filter_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rx_on && rx_st_r == ir_ctrl_pkg::RX_ADDR && rx_byte_i && !ctl_r.addr_filter_enable
        |=> rx_store_o)
        else $error("no store");
    a_keep_until_stop: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rx_on && rx_st_r == ir_ctrl_pkg::RX_KEEP && !rx_stop_i |=> rx_store_o)
        else $error("store ended early");
    a_drop_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rx_st_r == ir_ctrl_pkg::RX_DROP |=> !rx_store_o)
        else $error("dropped frame stored");

    c_abort: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) tx_send_abort_o);
    c_close: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) tx_send_close_o);
    c_store: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) rx_store_o);
    c_both:  cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        tx_clk_en_o && rx_clk_en_o);
    c_drop:  cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rx_st_r == ir_ctrl_pkg::RX_DROP);
endmodule // infrared_frame_control

// ---- inc/ir_ctrl_map.svh ----
`ifndef IR_CTRL_MAP_SVH
`define IR_CTRL_MAP_SVH
// Control register field positions
`define CTL_RATE_BIT      3'd1
`define CTL_UNDERRUN_BIT  3'd2
`define CTL_TXEN_BIT      3'd3
`define CTL_RXEN_BIT      3'd4
`define CTL_RXMASK_BIT    3'd5
`define CTL_TXMASK_BIT    3'd6
`define CTL_AFILT_BIT     3'd7
`define CTL_RESET         8'h00
`define CTL_WMASK         8'hfe
// Interface selection codes
`define SEL_NONE          2'h0
`define SEL_SLOW          2'h1
`define SEL_MED           2'h2
`define SEL_FAST          2'h3
// Bit clock: source ticks per bit, 83 or 41 after truncation (0.576 / 1.152 Mbit/s)
`define SRC_HZ            48000000
`define RATE_LO_BPS       576000
`define RATE_HI_BPS       1152000
`define DIV_LO            7'(`SRC_HZ / `RATE_LO_BPS)
`define DIV_HI            7'(`SRC_HZ / `RATE_HI_BPS)
`define BCAST_ADDR        8'hff
`endif

// ---- inc/ir_ctrl_pkg.sv ----
package ir_ctrl_pkg;
    typedef struct packed {
        logic addr_filter_enable;
        logic transmit_irq_mask;
        logic receive_irq_mask;
        logic receive_enable_bit;
        logic transmit_enable_bit;
        logic underrun_action_select;
        logic medium_rate_select;
        logic unused0;
    } infrared_control_s;

    typedef enum logic [3:0] {
        RX_HUNT = 4'b0001,
        RX_ADDR = 4'b0010,
        RX_KEEP = 4'b0100,
        RX_DROP = 4'b1000
    } rx_state_e;

    typedef enum logic [2:0] {
        TX_DATA  = 3'b001,
        TX_CLOSE = 3'b010,
        TX_ABORT = 3'b100
    } tx_state_e;
endpackage

// ---- logic/bit_clock_gen.sv ----
// Purpose: medium-rate bit clock enable from the 48 MHz source tick
// Assumes: src_tick_i pulses at 48 MHz equivalent rate
// Notes:   restart_i realigns the phase to a receive edge
`include "ir_ctrl_map.svh"
module bit_clock_gen (
    input  wire logic clk_sys_i,
    input  wire logic resetn_i,
    input  wire logic run_i,
    input  wire logic fast_i,
    input  wire logic restart_i,
    input  wire logic src_tick_i,
    output logic      bit_tick_o
);
    logic [6:0] cnt_r;
    wire  [6:0] limit = fast_i ? `DIV_HI : `DIV_LO;
    wire        wrap  = src_tick_i && (cnt_r >= limit - 7'd1);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r      <= 7'h00;
            bit_tick_o <= 1'b0;
        end else begin
            bit_tick_o <= run_i && wrap;
            if (!run_i || restart_i)
                cnt_r <= 7'h00;
            else if (wrap)
                cnt_r <= 7'h00;
            else if (src_tick_i)
                cnt_r <= cnt_r + 7'h01;
        end
    end
endmodule // bit_clock_gen

// ---- tb/ir_remote_station.sv ----
// Purpose: remote infrared station as seen through the receive decoder
// Assumes: tasks are called just after a rising clock edge
// Notes:   data is inverted beside its strobe, though send_frame ends with the body byte left on the bus
module ir_remote_station (
    // Clock
    input  wire logic       clk_sys_i,
    // Decoded receive events
    output logic            rx_line_o,
    output logic            rx_flag_o,
    output logic            rx_byte_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_stop_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {rx_line_o, rx_flag_o, rx_byte_o, rx_stop_o, rx_data_o} = '0;
    end

    // Event order: line, flag, byte, stop
    task automatic step(input logic [3:0] ev, input logic [7:0] d);
        {rx_line_o, rx_flag_o, rx_byte_o, rx_stop_o} <= ev;
        rx_data_o <= d;
        @(posedge clk_sys_i);
    endtask

    task automatic send_frame(input logic [7:0] addr, input logic [7:0] body);
        step(4'h4, ~addr);
        step(4'h2, addr);
        step(4'h0, ~addr);
        step(4'h2, body);
        step(4'h1, ~body);
        step(4'h0, body);
    endtask

    task automatic line_rise();
        step(4'h8, ~rx_data_o);
        step(4'h8, ~rx_data_o);
        step(4'h0, ~rx_data_o);
    endtask
endmodule // ir_remote_station

// ---- tb/infrared_frame_control_tb_top.sv ----
// Purpose: self-checking bench for infrared_frame_control
// Assumes: src_tick_i held high, so one source tick per clock
// Notes:   close and abort waits are bounded since their latency is not fixed
`include "ir_ctrl_map.svh"
module infrared_frame_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_sys_i, resetn_i, ctl_wr_i, src_tick_i, tx_close_done_i;
    logic [7:0] ctl_wdata_i, ctl_rdata_o, addr_filter_value_i, rx_data_i, g, d1;
    logic [1:0] codec_sel_i;
    logic       rx_line_i, rx_flag_i, rx_byte_i, rx_stop_i, store_seen;
    logic       transmit_underrun_flag_i, tx_data_avail_i, transmit_service_flag_i;
    logic       receive_service_flag_i, end_error_in_fifo_flag_i;
    logic       bit_tick_o, rx_clk_en_o, tx_clk_en_o, slow_en_o, tx_flush_o, rx_flush_o;
    logic       tx_send_close_o, tx_send_abort_o, rx_store_o;
    logic       tx_irq_o, rx_irq_o, underrun_irq_o, tx_dma_o, rx_dma_o;
    int         n_mismatch = 0;
    int         check_count = 0;
    // Rows: control, {underrun, tx service, rx service, end/error}, requests
    logic [16:0] rows [8] = '{{8'h00, 4'h6, 5'h03}, {8'h04, 4'h8, 5'h04},
        {8'h00, 4'h8, 5'h00}, {8'h20, 4'h2, 5'h09}, {8'h20, 4'h3, 5'h08},
        {8'h40, 4'h4, 5'h12}, {8'h64, 4'he, 5'h1f}, {8'h60, 4'h1, 5'h00}};
    // Frames: stored, control, address
    logic [16:0] frames [4] = '{{1'b1, 8'h10, 8'h34}, {1'b1, 8'h90, 8'h33},
        {1'b1, 8'h90, 8'hff}, {1'b0, 8'h90, 8'h34}};

    infrared_frame_control infrared_frame_control_i (
        .clk_sys_i, .resetn_i, .ctl_wr_i, .ctl_wdata_i, .ctl_rdata_o, .codec_sel_i,
        .addr_filter_value_i, .src_tick_i, .rx_line_i, .rx_flag_i, .rx_byte_i,
        .rx_data_i, .rx_stop_i, .transmit_underrun_flag_i, .tx_data_avail_i,
        .transmit_service_flag_i, .receive_service_flag_i, .end_error_in_fifo_flag_i,
        .tx_close_done_i, .bit_tick_o, .rx_clk_en_o, .tx_clk_en_o, .slow_en_o,
        .tx_flush_o, .rx_flush_o, .tx_send_close_o, .tx_send_abort_o, .rx_store_o,
        .tx_irq_o, .rx_irq_o, .underrun_irq_o, .tx_dma_o, .rx_dma_o);

    ir_remote_station ir_remote_station_i (
        .clk_sys_i, .rx_line_o(rx_line_i), .rx_flag_o(rx_flag_i), .rx_byte_o(rx_byte_i),
        .rx_data_o(rx_data_i), .rx_stop_o(rx_stop_i));

    always #12.5 clk_sys_i = ~clk_sys_i;

    always @(posedge clk_sys_i) begin
        if (rx_store_o === 1'b1) begin
            store_seen <= 1'b1;
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Trailing edge wait keeps two writes out of one time step
    task automatic wr(input logic [7:0] d);
        ctl_wdata_i <= d;
        ctl_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        ctl_wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic flags(input logic [4:0] f);
        {transmit_underrun_flag_i, transmit_service_flag_i, receive_service_flag_i,
         end_error_in_fifo_flag_i, tx_data_avail_i} <= f;
    endtask

    task automatic wait_lvl(input string what, ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 200) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        check(what, {7'h0, v}, {7'h0, s});
    endtask

    task automatic to_tick(output logic [7:0] c);
        c = 8'h00;
        do begin
            @(posedge clk_sys_i);
            #1;
            c++;
        end while (bit_tick_o !== 1'b1 && c < 8'hc8);
    endtask

    initial begin
        #150us;
        n_mismatch++;
        close_out();
    end

    initial begin
        {clk_sys_i, resetn_i, ctl_wr_i, ctl_wdata_i, codec_sel_i, tx_close_done_i} = '0;
        {addr_filter_value_i, store_seen} = '0;
        src_tick_i = 1'b1;
        flags(5'h00);
        repeat (6) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        check("reset readback", 8'h00, ctl_rdata_o);
        check("reset outputs", 8'h00, {tx_clk_en_o, rx_clk_en_o, slow_en_o, tx_flush_o,
            rx_flush_o, tx_send_close_o, tx_send_abort_o, rx_store_o});
        wr(8'he7);
        #1;
        check("readback bit0", 8'he6, ctl_rdata_o);
        wr(8'hff);
        #1;
        check("readback", 8'hfe, ctl_rdata_o);
        wr(8'h00);
        codec_sel_i <= `SEL_MED;
        foreach (rows[i]) begin
            wr(rows[i][16:9]);
            flags({rows[i][8:5], 1'b1});
            repeat (2) @(posedge clk_sys_i);
            #1;
            check("requests", {3'h0, rows[i][4:0]}, {3'h0, tx_irq_o, rx_irq_o,
                underrun_irq_o, tx_dma_o, rx_dma_o});
        end
        flags(5'h01);
        wr(8'h00);
        wr(8'h18);
        #1;
        check("clock enables", 8'h03, {6'h0, tx_clk_en_o, rx_clk_en_o});
        to_tick(g);
        to_tick(g);
        check("slow bit period", {1'b0, `DIV_LO}, g);
        wr(8'h1a);
        to_tick(g);
        to_tick(g);
        check("fast bit period", {1'b0, `DIV_HI}, g);
        repeat (5) @(posedge clk_sys_i);
        ir_remote_station_i.line_rise();
        to_tick(d1);
        to_tick(g);
        repeat (20) @(posedge clk_sys_i);
        ir_remote_station_i.line_rise();
        to_tick(g);
        check("realigned tick", d1, g);
        wr(8'h08);
        flags(5'h10);
        wait_lvl("close sent", tx_send_close_o, 1'b1);
        check("abort idle", 8'h00, {7'h0, tx_send_abort_o});
        repeat (2) @(posedge clk_sys_i);
        tx_close_done_i <= 1'b1;
        @(posedge clk_sys_i);
        tx_close_done_i <= 1'b0;
        // Buffer refilled before the underrun action changes
        flags(5'h01);
        wr(8'h1c);
        flags(5'h10);
        wait_lvl("abort sent", tx_send_abort_o, 1'b1);
        check("close idle", 8'h00, {7'h0, tx_send_close_o});
        repeat (2) @(posedge clk_sys_i);
        flags(5'h01);
        wait_lvl("abort ends", tx_send_abort_o, 1'b0);
        // Flush stands only in the cycle after the write, so look inside it
        ctl_wdata_i <= 8'h00;
        ctl_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        ctl_wr_i <= 1'b0;
        #1;
        check("flush", 8'h03, {6'h0, tx_flush_o, rx_flush_o});
        @(posedge clk_sys_i);
        #1;
        check("flush ends", 8'h00, {4'h0, tx_flush_o, rx_flush_o, tx_clk_en_o,
            rx_clk_en_o});
        codec_sel_i <= `SEL_SLOW;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check("slow codec on", 8'h01, {7'h0, slow_en_o});
        codec_sel_i <= `SEL_MED;
        addr_filter_value_i <= 8'h33;
        foreach (frames[i]) begin
            wr(frames[i][15:8]);
            store_seen = 1'b0;
            ir_remote_station_i.send_frame(frames[i][7:0], 8'h33);
            repeat (2) @(posedge clk_sys_i);
            check("frame stored", {7'h0, frames[i][16]}, {7'h0, store_seen});
        end
        wr(8'h00);
        codec_sel_i <= `SEL_FAST;
        wr(8'h1a);
        #1;
        check("fast clock enables", 8'h03, {6'h0, tx_clk_en_o, rx_clk_en_o});
        to_tick(g);
        check("no medium tick", 8'hc8, g);
        close_out();
    end
endmodule // infrared_frame_control_tb_top
